//--- hdl/stepper_pulse_direction_controller.sv
`timescale 1ns/1ps
`default_nettype none
module stepper_pulse_direction_controller (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        soft_reset,
  output logic             dout1,
  output logic             dout2
);
  localparam int RW = stepper_pkg::RATE_W;
  localparam int AW = stepper_pkg::RAMP_W;
  localparam int FW = stepper_pkg::NUM_FLAGS;
  localparam int PW = stepper_pkg::PULSE_W;
  localparam logic [PW-1:0] PULSE_CYC = PW'(stepper_pkg::STEP_HIGH_CYC);

  function automatic logic [RW-1:0] base_rate(input logic [RW-1:0] r);
    base_rate = (r < 8) ? RW'(1) : (r >> 3);
  endfunction : base_rate

  function automatic logic [31:0] magnitude(input logic neg, input logic [31:0] v);
    magnitude = neg ? (~v + 32'h0000_0001) : v;
  endfunction : magnitude

  logic [RW-1:0]       max_rate;
  logic [AW-1:0]       ramp_len;
  logic [31:0]         move_count;
  logic [31:0]         target;
  logic signed [31:0]  position;
  logic [2:0]          config_bits;
  logic [FW-1:0]       done_flags;
  logic [2:0]          flag_sel;
  stepper_pkg::motion_state_t state;
  logic                dir_neg;
  logic [31:0]         remain;
  logic [AW-1:0]       done_steps;
  logic [RW-1:0]       cur_rate;
  logic                div_start;
  logic [PW-1:0]       pulse_cnt;

  // Bus decode
  wire setup    = psel & ~penable;
  wire wr_en    = psel & penable & pready & pwrite & ~pslverr;
  wire hit_cmd  = paddr == stepper_pkg::OFF_CMD;
  wire hit_rate = paddr == stepper_pkg::OFF_RATE;
  wire hit_ramp = paddr == stepper_pkg::OFF_RAMP;
  wire hit_cnt  = paddr == stepper_pkg::OFF_COUNT;
  wire hit_tgt  = paddr == stepper_pkg::OFF_TARGET;
  wire hit_pos  = paddr == stepper_pkg::OFF_POS;
  wire hit_stat = paddr == stepper_pkg::OFF_STATUS;
  wire hit_rem  = paddr == stepper_pkg::OFF_REMAIN;
  wire hit_cfg  = paddr == stepper_pkg::OFF_CONFIG;
  wire mapped   = hit_cmd | hit_rate | hit_ramp | hit_cnt | hit_tgt | hit_pos | hit_stat | hit_rem | hit_cfg;

  wire idle   = state == stepper_pkg::ST_IDLE;
  wire [31:0] status_word = {16'h0000, FW'(done_flags), 7'h00, ~idle};

  wire [31:0] rd_mux =
    hit_rate ? {{(32-RW){1'b0}}, max_rate} :
    hit_ramp ? {{(32-AW){1'b0}}, ramp_len} :
    hit_cnt  ? move_count :
    hit_tgt  ? target :
    hit_pos  ? position :
    hit_stat ? status_word :
    hit_rem  ? remain :
    hit_cfg  ? {29'h0, config_bits} : 32'h0000_0000;

  // Commands
  wire cmd_wr   = wr_en & hit_cmd;
  wire ch_ok    = pwdata[stepper_pkg::CMD_CH_LSB +: 4] == stepper_pkg::CHANNEL_CTRL;
  wire cmd_ok   = cmd_wr & ch_ok;
  wire abort_go = cmd_ok & pwdata[stepper_pkg::CMD_ABORT_BIT];
  wire rel_go   = cmd_ok & idle & ~abort_go & pwdata[stepper_pkg::CMD_REL_BIT];
  wire abs_go   = cmd_ok & idle & ~abort_go & ~rel_go & pwdata[stepper_pkg::CMD_ABS_BIT];
  wire home_go  = cmd_ok & idle & pwdata[stepper_pkg::CMD_HOME_BIT];
  wire move_go  = rel_go | abs_go;
  wire [2:0] new_flag = pwdata[stepper_pkg::CMD_FLAG_LSB +: 3];

  // Absolute target against present position, one bit wider to avoid overflow
  wire signed [32:0] abs_diff = {target[31], target} - {position[31], position};
  wire        abs_neg = abs_diff[32];
  wire [31:0] abs_mag = magnitude(abs_neg, abs_diff[31:0]);
  wire        rel_neg = move_count[31];
  wire [31:0] rel_mag = magnitude(rel_neg, move_count);
  wire        go_neg  = rel_go ? rel_neg : abs_neg;
  wire [31:0] go_mag  = rel_go ? rel_mag : abs_mag;

  // Profile point: steps from the nearer end, capped at the ramp length
  wire [31:0]   rem_m1  = remain - 32'h0000_0001;
  wire [AW-1:0] to_end  = (rem_m1 > 32'(ramp_len)) ? ramp_len : rem_m1[AW-1:0];
  wire [AW-1:0] ramp_pt = (done_steps < to_end) ? done_steps : to_end;
  wire [RW-1:0] base    = base_rate(max_rate);
  wire [RW-1:0] span    = max_rate - base;
  wire [31:0]   div_num = 32'(span) * 32'(ramp_pt);
  wire          flat    = ramp_len == '0;
  wire          div_done;
  wire [31:0]   div_quo;
  wire          tick;

  serial_divider #(
    .NUM_W (32),
    .DEN_W (AW)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (div_start),
    .num     (div_num),
    .den     (ramp_len),
    .done    (div_done),
    .quo     (div_quo)
  );

  phase_step_gen #(
    .RATE_W  (RW),
    .PHASE_W (stepper_pkg::PHASE_W)
  ) u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (move_go),
    .run     (state == stepper_pkg::ST_RUN),
    .rate    (cur_rate),
    .tick    (tick)
  );

  wire last_step = remain == 32'h0000_0001;

  // Bus answer: one setup, one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Profile settings are cleared by power-on reset only, never by soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_rate    <= stepper_pkg::RATE_RST;
      ramp_len    <= stepper_pkg::RAMP_RST;
      move_count  <= 32'h0000_0000;
      target      <= 32'h0000_0000;
      config_bits <= stepper_pkg::CONFIG_RST;
    end else begin
      if (wr_en & hit_rate)
        max_rate <= pwdata[RW-1:0];
      if (wr_en & hit_ramp)
        ramp_len <= pwdata[AW-1:0];
      if (wr_en & hit_cnt)
        move_count <= pwdata;
      if (wr_en & hit_tgt)
        target <= pwdata;
      if (wr_en & hit_cfg)
        config_bits <= pwdata[2:0];
    end
  end

  // Motion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= stepper_pkg::ST_IDLE;
      dir_neg    <= 1'b0;
      remain     <= 32'h0000_0000;
      done_steps <= '0;
      cur_rate   <= '0;
      div_start  <= 1'b0;
      flag_sel   <= 3'h0;
      done_flags <= stepper_pkg::FLAGS_RST;
      position   <= 32'sh0000_0000;
    end else if (soft_reset) begin
      state      <= stepper_pkg::ST_IDLE;
      remain     <= 32'h0000_0000;
      div_start  <= 1'b0;
      done_flags <= stepper_pkg::FLAGS_RST;
    end else begin
      div_start <= 1'b0;
      if (home_go)
        position <= 32'sh0000_0000;
      if (abort_go) begin
        state  <= stepper_pkg::ST_IDLE;
        remain <= 32'h0000_0000;
      end else begin
        case (state)
          stepper_pkg::ST_IDLE: begin
            if (move_go) begin
              flag_sel   <= new_flag;
              dir_neg    <= go_neg;
              remain     <= go_mag;
              done_steps <= '0;
              if (go_mag == 32'h0000_0000)
                done_flags[new_flag] <= 1'b1;
              else begin
                done_flags[new_flag] <= 1'b0;
                state                <= stepper_pkg::ST_CALC;
                div_start            <= 1'b1;
              end
            end
          end
          stepper_pkg::ST_CALC: begin
            // Flat profile skips the divider, which cannot divide by zero
            if (flat) begin
              cur_rate <= max_rate;
              state    <= stepper_pkg::ST_RUN;
            end else if (div_done) begin
              cur_rate <= base + div_quo[RW-1:0];
              state    <= stepper_pkg::ST_RUN;
            end
          end
          stepper_pkg::ST_RUN: begin
            if (tick) begin
              position   <= dir_neg ? position - 32'sd1 : position + 32'sd1;
              remain     <= remain - 32'h0000_0001;
              done_steps <= (done_steps == ramp_len) ? done_steps : done_steps + 1'b1;
              if (last_step) begin
                state                <= stepper_pkg::ST_IDLE;
                done_flags[flag_sel] <= 1'b1;
              end else begin
                state     <= stepper_pkg::ST_CALC;
                div_start <= ~flat;
              end
            end
          end
          default: state <= stepper_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Step pulse width; an abort lets a started pulse finish so the driver sees no runt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pulse_cnt <= '0;
    else if (state == stepper_pkg::ST_RUN && tick && !abort_go && !soft_reset)
      pulse_cnt <= PULSE_CYC;
    else if (pulse_cnt != '0)
      pulse_cnt <= pulse_cnt - 1'b1;
  end

  // Output pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout1 <= 1'b0;
      dout2 <= 1'b0;
    end else if (config_bits[stepper_pkg::CFG_EN_BIT]) begin
      // Direction waits out a running pulse; a new move may start during the last one
      if (pulse_cnt == '0)
        dout1 <= dir_neg;
      dout2 <= pulse_cnt != '0;
    end else begin
      dout1 <= config_bits[stepper_pkg::CFG_GP1_BIT];
      dout2 <= config_bits[stepper_pkg::CFG_GP2_BIT];
    end
  end
endmodule : stepper_pulse_direction_controller
`default_nettype wire

//--- hdl/stepper_pkg.sv
package stepper_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int unsigned STEP_HIGH_NS  = 20_000;
  localparam int unsigned STEP_HIGH_CYC = (STEP_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_PPS       = 10000;
  localparam int unsigned PHASE_W       = 25;

  localparam int unsigned RATE_W    = 14;
  localparam int unsigned RAMP_W    = 16;
  localparam int unsigned NUM_FLAGS = 8;
  localparam int unsigned PULSE_W   = 10;

  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_RATE   = 8'h04;
  localparam logic [7:0] OFF_RAMP   = 8'h08;
  localparam logic [7:0] OFF_COUNT  = 8'h0c;
  localparam logic [7:0] OFF_TARGET = 8'h10;
  localparam logic [7:0] OFF_POS    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_REMAIN = 8'h1c;
  localparam logic [7:0] OFF_CONFIG = 8'h20;

  localparam int unsigned CMD_REL_BIT   = 0;
  localparam int unsigned CMD_ABS_BIT   = 1;
  localparam int unsigned CMD_ABORT_BIT = 2;
  localparam int unsigned CMD_HOME_BIT  = 3;
  localparam int unsigned CMD_CH_LSB    = 4;
  localparam int unsigned CMD_FLAG_LSB  = 8;
  localparam logic [3:0]  CHANNEL_CTRL  = 4'h1;

  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_FLAG_LSB = 8;

  localparam int unsigned CFG_EN_BIT  = 0;
  localparam int unsigned CFG_GP1_BIT = 1;
  localparam int unsigned CFG_GP2_BIT = 2;

  localparam logic [RATE_W-1:0]    RATE_RST   = 14'h0000;
  localparam logic [RAMP_W-1:0]    RAMP_RST   = 16'h0000;
  localparam logic [2:0]           CONFIG_RST = 3'h0;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST  = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RUN} motion_state_t;

endpackage : stepper_pkg

//--- hdl/serial_divider.sv
`timescale 1ns/1ps
`default_nettype none
module serial_divider #(
  parameter int NUM_W = 32,
  parameter int DEN_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [DEN_W-1:0] den,
  output logic                  done,
  output logic      [NUM_W-1:0] quo
);
  localparam int CNT_W = $clog2(NUM_W + 1);

  logic [DEN_W-1:0] rem;
  logic [CNT_W-1:0] cnt;
  logic             busy;

  // Remainder stays below the divisor, so one extra bit covers the shift
  wire [DEN_W:0] trial = {rem, quo[NUM_W-1]};
  wire           fits  = trial >= {1'b0, den};
  wire [DEN_W:0] diff  = trial - {1'b0, den};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem  <= '0;
      quo  <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      rem  <= '0;
      quo  <= num;
      cnt  <= CNT_W'(NUM_W);
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      rem  <= fits ? diff[DEN_W-1:0] : trial[DEN_W-1:0];
      quo  <= {quo[NUM_W-2:0], fits};
      cnt  <= cnt - 1'b1;
      busy <= cnt != 1;
      done <= cnt == 1;
    end else begin
      done <= 1'b0;
    end
  end
endmodule : serial_divider
`default_nettype wire

//--- hdl/phase_step_gen.sv
`timescale 1ns/1ps
`default_nettype none
module phase_step_gen #(
  parameter int RATE_W  = stepper_pkg::RATE_W,
  parameter int PHASE_W = stepper_pkg::PHASE_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clear,
  input  wire logic              run,
  input  wire logic [RATE_W-1:0] rate,
  output logic                   tick
);
  localparam logic [PHASE_W:0] MODULUS = (PHASE_W + 1)'(stepper_pkg::CLK_HZ);

  // Exact average rate: add pps each clock, wrap at one second of clocks
  logic [PHASE_W-1:0] acc;
  wire  [PHASE_W:0]   sum  = {1'b0, acc} + (PHASE_W + 1)'(rate);
  wire                wrap = sum >= MODULUS;
  wire  [PHASE_W:0]   left = sum - MODULUS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc  <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      acc  <= '0;
      tick <= 1'b0;
    end else if (run) begin
      acc  <= wrap ? left[PHASE_W-1:0] : sum[PHASE_W-1:0];
      tick <= wrap;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule : phase_step_gen
`default_nettype wire

//--- verif/step_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pulse/direction power stage: counts steps, moves its rotor by the sampled direction
module step_driver_model (
  input  wire logic dir,
  input  wire logic step,
  output int        pulses,
  output int        motor_pos
);
  initial begin
    pulses = 0;
    motor_pos = 0;
  end
  // Direction sampled at the step edge, as a real stage latches it
  always @(posedge step) begin
    pulses <= pulses + 1;
    motor_pos <= dir ? motor_pos - 1 : motor_pos + 1;
  end
endmodule : step_driver_model
`default_nettype wire

//--- verif/stepper_pulse_direction_controller_props.sv
`timescale 1ns/1ps
`default_nettype none
module stepper_pdc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        soft_reset,
  input wire logic        dout1,
  input wire logic        dout2
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] hi_cnt;
  logic [15:0] gap_cnt;
  logic        step_q;
  wire         setup = psel && !penable;
  // Saturating gap counter, so long idle spans never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt  <= 16'h0000;
      gap_cnt <= 16'hffff;
      step_q  <= 1'b0;
    end else begin
      step_q  <= dout2;
      hi_cnt  <= dout2 ? hi_cnt + 16'h0001 : 16'h0000;
      gap_cnt <= (dout2 && !step_q) ? 16'h0001 : (gap_cnt == 16'hffff ? gap_cnt : gap_cnt + 16'h0001);
    end
  end
  a_ready_setup: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_cause: assert property (pready |-> $past(setup)) else $error("ready without setup");
  a_err_unmapped: assert property (setup && paddr > 8'h20 && paddr[1:0] == 2'h0 |=> pslverr)
    else $error("unmapped address not flagged");
  a_err_mapped: assert property (setup && paddr == stepper_pkg::OFF_RATE |=> !pslverr) else $error("bad error");
  a_cmd_rdzero: assert property (setup && !pwrite && paddr == stepper_pkg::OFF_CMD |=> prdata == 32'h0)
    else $error("command register read not zero");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_pulse_width: assert property ($fell(dout2) |-> hi_cnt == 16'd500) else $error("step pulse width");
  a_step_gap: assert property ($rose(dout2) |-> gap_cnt >= 16'd2500) else $error("step rate too high");
  a_dir_hold: assert property (dout2 |-> $stable(dout1)) else $error("direction moved in pulse");
endmodule : stepper_pdc_props
bind stepper_pulse_direction_controller stepper_pdc_props props_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset), .dout1(dout1), .dout2(dout2));
`default_nettype wire

//--- verif/tb_stepper_pulse_direction_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_stepper_pulse_direction_controller;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        soft_reset = 1'b0;
  logic        dout1;
  logic        dout2;
  int          pulses;
  int          motor_pos;
  int          fails = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  logic        err;
  int          p0;
  always #20 pclk = ~pclk;
  stepper_pulse_direction_controller dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(soft_reset), .dout1(dout1), .dout2(dout2));
  step_driver_model drv_u (.dir(dout1), .step(dout2), .pulses(pulses), .motor_pos(motor_pos));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cmdw(input logic [3:0] op, input logic [2:0] fl);
    return {21'h0, fl, stepper_pkg::CHANNEL_CTRL, op};
  endfunction : cmdw
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, stepper_pkg::OFF_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20000);
    if (n >= 20000) chk(32'h0, 32'h1);
  endtask : wait_idle
  task automatic move(input logic [7:0] a, input logic [31:0] v, input logic [31:0] c);
    p0 = pulses;
    apb(1'b1, a, v);
    apb(1'b1, stepper_pkg::OFF_CMD, c);
  endtask : move
  task automatic t_regs();
    apb(1'b0, stepper_pkg::OFF_RATE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, stepper_pkg::OFF_CONFIG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, stepper_pkg::OFF_RATE, 32'd10000);
    apb(1'b0, stepper_pkg::OFF_RATE, 32'h0);
    chk(rd, 32'd10000);
    apb(1'b0, stepper_pkg::OFF_CMD, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, stepper_pkg::OFF_CONFIG, 32'h2);
    repeat (2) @(posedge pclk);
    chk({30'h0, dout2, dout1}, 32'h1);
    apb(1'b1, stepper_pkg::OFF_CONFIG, 32'h1);
    apb(1'b1, stepper_pkg::OFF_RAMP, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_rel();
    move(stepper_pkg::OFF_COUNT, 32'd3, cmdw(4'h1, 3'd2));
    apb(1'b0, stepper_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h0401, 32'h0001);
    move(stepper_pkg::OFF_COUNT, 32'd9, cmdw(4'h1, 3'd2));
    wait_idle();
    chk(pulses - p0, 32'd3);
    chk(rd & 32'h0401, 32'h0400);
    apb(1'b0, stepper_pkg::OFF_POS, 32'h0);
    chk(rd, 32'd3);
    chk({31'h0, dout1}, 32'h0);
    move(stepper_pkg::OFF_COUNT, 32'hffff_fffe, cmdw(4'h1, 3'd2));
    repeat (3000) @(posedge pclk);
    chk({31'h0, dout1}, 32'h1);
    apb(1'b0, stepper_pkg::OFF_POS, 32'h0);
    chk(rd, 32'd2);
    wait_idle();
    chk(pulses - p0, 32'd2);
    $display("test relative done");
  endtask : t_rel
  task automatic t_abs();
    apb(1'b1, stepper_pkg::OFF_CMD, cmdw(4'h8, 3'd0));
    apb(1'b0, stepper_pkg::OFF_POS, 32'h0);
    chk(rd, 32'h0);
    move(stepper_pkg::OFF_TARGET, 32'hffff_fffe, cmdw(4'h2, 3'd5));
    apb(1'b0, stepper_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h2001, 32'h0001);
    wait_idle();
    chk(rd & 32'h2001, 32'h2000);
    chk(pulses - p0, 32'd2);
    apb(1'b0, stepper_pkg::OFF_POS, 32'h0);
    chk(rd, 32'hffff_fffe);
    // Wrong channel code: the whole command must be dropped
    apb(1'b1, stepper_pkg::OFF_CMD, 32'h0000_0021);
    apb(1'b0, stepper_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h0000_0001, 32'h0);
    $display("test absolute done");
  endtask : t_abs
  task automatic t_abort();
    move(stepper_pkg::OFF_COUNT, 32'd100, cmdw(4'h1, 3'd1));
    repeat (3000) @(posedge pclk);
    apb(1'b1, stepper_pkg::OFF_CMD, cmdw(4'h4, 3'd0));
    apb(1'b0, stepper_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h0201, 32'h0);
    repeat (3000) @(posedge pclk);
    apb(1'b0, stepper_pkg::OFF_POS, 32'h0);
    chk(rd, 32'hffff_ffff);
    move(stepper_pkg::OFF_COUNT, 32'd2, cmdw(4'h1, 3'd1));
    wait_idle();
    chk(pulses - p0, 32'd2);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    apb(1'b0, stepper_pkg::OFF_RATE, 32'h0);
    chk(rd, 32'd10000);
    apb(1'b0, stepper_pkg::OFF_POS, 32'h0);
    chk(rd, 32'h1);
    $display("test abort and soft reset done");
  endtask : t_abort
  // Short ramp keeps the slow base-rate steps few, yet shows both ramp ends
  task automatic t_ramp();
    int n;
    apb(1'b1, stepper_pkg::OFF_RAMP, 32'h1);
    move(stepper_pkg::OFF_COUNT, 32'd3, cmdw(4'h1, 3'd0));
    for (n = 0; n < 30000 && pulses == p0; n++) @(posedge pclk);
    chk({31'h0, n >= 19000 && n < 21000}, 32'h1);
    for (n = 0; n < 30000 && pulses == p0 + 1; n++) @(posedge pclk);
    chk({31'h0, n >= 2400 && n < 3000}, 32'h1);
    for (n = 0; n < 30000 && pulses == p0 + 2; n++) @(posedge pclk);
    chk({31'h0, n >= 19000 && n < 21000}, 32'h1);
    wait_idle();
    chk(pulses - p0, 32'd3);
    $display("test ramp done");
  endtask : t_ramp
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rel();
    t_abs();
    t_abort();
    t_ramp();
    test_done();
  end
  initial begin
    #(90000 * 40);
    fails++;
    test_done();
  end
endmodule : tb_stepper_pulse_direction_controller
`default_nettype wire
